/* File: logic/chsp_ctl_end.sv */
// controller end: axi4-lite registers drive framed transfers on the serial link
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "chsp_consts.svh"
module chsp_ctl_end
	import chsp_pkg::*;
#(
	parameter int HALF = `CHSP_SCLK_HALF_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	chsp_link_if.ctl         link
);
	logic [3:0]  aw_q;
	logic [31:0] wd_q;
	logic [31:0] wmask;
	logic        aw_got;
	logic        w_got;
	logic        start;
	logic [22:0] tx_cmd;
	logic        crc_en;
	logic [31:0] rx_word;
	logic        rx_crc_ok;
	logic        rx_sync_ok;
	chsp_state_e state;
	logic [7:0]  tmr;
	logic [5:0]  bits;
	logic [31:0] sh;
	logic [31:0] rx;
	logic [31:0] rx_al;
	logic        sclk_q;
	logic        sync_q;
	logic        sdi_q;
	logic [7:0]  tx_crc;
	logic [7:0]  rx_crc;
	logic        d1;
	logic        d2;
	logic        d3;
	logic        sdo_lvl;

	// byte-lane mask from the write strobes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = {8{s_axi_wstrb[i]}};
		end
	end

	// write channel: address and data taken in either order, then response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= 4'h0;
			wd_q <= 32'h0000_0000;
			tx_cmd <= 23'h00_0000;
			crc_en <= `CHSP_CRC_EN_RST;
			start <= 1'b0;
		end else begin
			start <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= s_axi_awaddr;
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_q <= s_axi_wdata & wmask;
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				if (aw_q == `CHSP_OFS_TX) begin
					if (state == CHSP_ST_IDLE && !start) begin
						tx_cmd <= wd_q[22:0];
						start <= 1'b1;
					end
				end else if (aw_q == `CHSP_OFS_CTRL) begin
					crc_en <= wd_q[0];
				end else if (aw_q != `CHSP_OFS_RX && aw_q != `CHSP_OFS_STAT) begin
					s_axi_bresp <= 2'b10;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			if (s_axi_araddr == `CHSP_OFS_TX) begin
				s_axi_rdata <= {9'h000, tx_cmd};
			end else if (s_axi_araddr == `CHSP_OFS_CTRL) begin
				s_axi_rdata <= {31'h0000_0000, crc_en};
			end else if (s_axi_araddr == `CHSP_OFS_RX) begin
				s_axi_rdata <= rx_word;
			end else if (s_axi_araddr == `CHSP_OFS_STAT) begin
				s_axi_rdata <= {29'h0000_0000, rx_sync_ok, rx_crc_ok, state != CHSP_ST_IDLE};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// returned data pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			d1 <= 1'b1;
			d2 <= 1'b1;
			d3 <= 1'b1;
			sdo_lvl <= 1'b1;
		end else begin
			d1 <= link.sdo;
			d2 <= d1;
			d3 <= d2;
			if (d2 == d3) begin
				sdo_lvl <= d2;
			end
		end
	end

	// check bytes for the outgoing command and the returned frame
	chsp_crc8 #(.W(24)) u_tx_crc (
		.data ({~tx_cmd[22], tx_cmd}),
		.crc  (tx_crc)
	);
	assign rx_al = crc_en ? rx : {rx[23:0], 8'h00};
	chsp_crc8 #(.W(24)) u_rx_crc (
		.data (rx_al[31:8]),
		.crc  (rx_crc)
	);

	// frame sequencer: clock idles high, data changes on rise, device samples on fall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= CHSP_ST_IDLE;
			tmr <= 8'h00;
			bits <= 6'h00;
			sh <= 32'h0000_0000;
			rx <= 32'h0000_0000;
			sclk_q <= 1'b1;
			sync_q <= 1'b1;
			sdi_q <= 1'b0;
			rx_word <= 32'h0000_0000;
			rx_crc_ok <= 1'b0;
			rx_sync_ok <= 1'b0;
		end else begin
			if (tmr != 8'h00) begin
				tmr <= tmr - 8'h01;
			end
			case (state)
				CHSP_ST_IDLE: begin
					if (start) begin
						sh <= {~tx_cmd[22], tx_cmd, crc_en ? tx_crc : 8'h00};
						sdi_q <= ~tx_cmd[22];
						sync_q <= 1'b0;
						bits <= 6'h00;
						tmr <= 8'(HALF - 1);
						state <= CHSP_ST_LEAD;
					end
				end
				CHSP_ST_LEAD, CHSP_ST_HIGH: begin
					if (tmr == 8'h00) begin
						sclk_q <= 1'b0;
						tmr <= 8'(HALF - 1);
						state <= CHSP_ST_LOW;
					end
				end
				CHSP_ST_LOW: begin
					if (tmr == 8'h00) begin
						sclk_q <= 1'b1;
						rx <= {rx[30:0], sdo_lvl};
						bits <= bits + 6'h01;
						tmr <= 8'(HALF - 1);
						if (bits == (crc_en ? `CHSP_FULL_BITS : `CHSP_SHORT_BITS) - 6'h01) begin
							state <= CHSP_ST_TAIL;
						end else begin
							sh <= {sh[30:0], 1'b0};
							sdi_q <= sh[30];
							state <= CHSP_ST_HIGH;
						end
					end
				end
				CHSP_ST_TAIL: begin
					if (tmr == 8'h00) begin
						sync_q <= 1'b1;
						sdi_q <= 1'b0;
						tmr <= 8'(HALF - 1);
						state <= CHSP_ST_GAP;
					end
				end
				CHSP_ST_GAP: begin
					if (tmr == 8'h00) begin
						rx_word <= rx_al;
						rx_crc_ok <= !crc_en || rx_crc == rx_al[7:0];
						rx_sync_ok <= rx_al[31:30] == `CHSP_SYNC_PAT;
						state <= CHSP_ST_IDLE;
					end
				end
				default: begin
					state <= CHSP_ST_IDLE;
				end
			endcase
		end
	end
	assign link.sclk   = sclk_q;
	assign link.sync_n = sync_q;
	assign link.sdi    = sdi_q;
endmodule
`default_nettype wire

/* File: logic/chsp_consts.svh */
// constants of the checked serial host port: frame layout, register map, timing
`ifndef CHSP_CONSTS_SVH
`define CHSP_CONSTS_SVH
// frame layout
`define CHSP_FULL_BITS    6'h20
`define CHSP_SHORT_BITS   6'h18
`define CHSP_CRC_POLY     8'h07
`define CHSP_CRC_INIT     8'h00
`define CHSP_SYNC_PAT     2'h2
// device register addresses (5-bit)
`define CHSP_REG_NOP      5'h00
`define CHSP_REG_RB_SEL   5'h01
`define CHSP_REG_CTRL     5'h02
`define CHSP_REG_FLT_CFG  5'h03
`define CHSP_REG_DIAG     5'h04
`define CHSP_REG_STATUS   5'h05
// device field positions and reset values
`define CHSP_CTRL_CRC_EN  0
`define CHSP_CTRL_MODE_LO 1
`define CHSP_DIAG_CRC     0
`define CHSP_DIAG_GUARD   1
`define CHSP_DIAG_COUNT   2
`define CHSP_CRC_EN_RST   1'b1
`define CHSP_FLT_CFG_RST  1'b1
// controller register byte offsets
`define CHSP_OFS_TX       4'h0
`define CHSP_OFS_CTRL     4'h4
`define CHSP_OFS_RX       4'h8
`define CHSP_OFS_STAT     4'hc
// timing
`define CHSP_CLK_NS       50
`define CHSP_SCLK_HALF_NS 400
`define CHSP_SCLK_HALF_CYC ((`CHSP_SCLK_HALF_NS + `CHSP_CLK_NS - 1) / `CHSP_CLK_NS)
`endif

/* File: logic/chsp_pkg.sv */
// types shared by both ends of the checked serial host port
`default_nettype none
package chsp_pkg;
	typedef enum logic [1:0] {
		CHSP_RB_TWO_STAGE = 2'b00,
		CHSP_RB_AUTO      = 2'b01,
		CHSP_RB_SHARED    = 2'b10,
		CHSP_RB_ECHO      = 2'b11
	} chsp_rb_mode_e;
	typedef enum logic [2:0] {
		CHSP_ST_IDLE = 3'b000,
		CHSP_ST_LEAD = 3'b001,
		CHSP_ST_LOW  = 3'b010,
		CHSP_ST_HIGH = 3'b011,
		CHSP_ST_TAIL = 3'b100,
		CHSP_ST_GAP  = 3'b101
	} chsp_state_e;
endpackage
`default_nettype wire

/* File: logic/chsp_link_if.sv */
// four-wire serial link between the controller end and the device end
`timescale 1ns/10ps
`default_nettype none
interface chsp_link_if;
	logic sclk;
	logic sync_n;
	logic sdi;
	logic sdo_o;
	logic sdo_oe;
	logic sdo;
	// released line reads high through the pull-up
	assign sdo = sdo_oe ? sdo_o : 1'b1;
	modport dev (input sclk, input sync_n, input sdi, output sdo_o, output sdo_oe);
	modport ctl (output sclk, output sync_n, output sdi, input sdo);
endinterface
`default_nettype wire

/* File: logic/chsp_crc8.sv */
// combinational 8-bit check byte over a word, msb first, zero start
`timescale 1ns/10ps
`default_nettype none
`include "chsp_consts.svh"
module chsp_crc8 #(
	parameter int W = 24
) (
	input  wire logic [W-1:0] data,
	output logic      [7:0]   crc
);
	// bitwise long division by the check polynomial
	always_comb begin
		logic fb;
		fb = 1'b0;
		crc = `CHSP_CRC_INIT;
		for (int i = W - 1; i >= 0; i--) begin
			fb = crc[7] ^ data[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? `CHSP_CRC_POLY : 8'h00);
		end
	end
endmodule
`default_nettype wire

/* File: logic/chsp_dev_end.sv */
// device end of the checked serial host port: frame checks, registers, readback
// Overview of operation
// - shift 32 input bits, msb first
// - sample input data on clock falling edge
// - checking enabled after reset until cleared
// - checking off: 24-bit frame, trailing 8 dropped
// - guard, board address, register, data, check
// - accept only when board address matches straps
// - check byte uses x8+x2+x+1
// - controller shifts exactly 32 bits when checking
// - bad check: discard, fault low, status bits
// - sticky check error, write one clears
// - fault configuration gates check error onto fault
// - outgoing frames carry a check byte
// - guard bit must invert next bit
// - exactly 32 or 24 falling edges
// - four readback modes selectable
// - select register, then no-op returns it
// - readback frame: 10, fault, address, data, check
// - auto status off at reset, every frame
// - echo mode alternates status and last command
`timescale 1ns/10ps
`default_nettype none
`include "chsp_consts.svh"
module chsp_dev_end
	import chsp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	chsp_link_if.dev         link,
	input  wire logic        board_addr_strap0,
	input  wire logic        board_addr_strap1,
	output logic             fault_n,
	output logic             wr_valid,
	output logic [4:0]       wr_addr,
	output logic [15:0]      wr_data
);
	// pin index: 0 sclk, 1 sync_n, 2 sdi, 3 strap0, 4 strap1
	logic [4:0]    s1;
	logic [4:0]    s2;
	logic [4:0]    s3;
	logic [4:0]    lvl;
	logic [4:0]    next_lvl;
	logic          sync_fall;
	logic          sync_rise;
	logic          clk_fall;
	logic          clk_rise;
	logic [31:0]   rx_sh;
	logic [5:0]    edge_cnt;
	logic [31:0]   tx_sh;
	logic          crc_en;
	chsp_rb_mode_e rb_mode;
	logic [4:0]    rb_sel;
	logic          flt_cfg;
	logic [2:0]    diag;
	logic [23:0]   echo_word;
	logic          echo_phase;
	logic          addr_hit;
	logic          sdo_oe_q;
	logic [23:0]   frame24;
	logic [7:0]    rx_crc;
	logic          len_ok;
	logic          crc_ok;
	logic          guard_ok;
	logic          addr_ok;
	logic          accept;
	logic [2:0]    diag_set;
	logic [2:0]    diag_clr;
	logic [4:0]    cmd_reg;
	logic [15:0]   cmd_data;
	logic [15:0]   status_word;
	logic [15:0]   sel_data;
	logic [23:0]   tx_word;
	logic [7:0]    tx_crc;

	// three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= 5'b0_0011;
			s2 <= 5'b0_0011;
			s3 <= 5'b0_0011;
			lvl <= 5'b0_0011;
		end else begin
			s1 <= {board_addr_strap1, board_addr_strap0, link.sdi, link.sync_n, link.sclk};
			s2 <= s1;
			s3 <= s2;
			lvl <= next_lvl;
		end
	end
	assign next_lvl = (s2 & ~(s2 ^ s3)) | (lvl & (s2 ^ s3));

	// link events seen in the aclk domain
	assign sync_fall = lvl[1] & ~next_lvl[1];
	assign sync_rise = ~lvl[1] & next_lvl[1];
	assign clk_fall  = ~lvl[1] & lvl[0] & ~next_lvl[0];
	assign clk_rise  = ~lvl[1] & ~lvl[0] & next_lvl[0];

	// input shift register and falling-edge counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sh <= 32'h0000_0000;
			edge_cnt <= 6'h00;
		end else if (sync_fall) begin
			rx_sh <= 32'h0000_0000;
			edge_cnt <= 6'h00;
		end else if (clk_fall) begin
			rx_sh <= {rx_sh[30:0], next_lvl[2]};
			if (edge_cnt != 6'h3f) begin
				edge_cnt <= edge_cnt + 6'h01;
			end
		end
	end

	// frame checks evaluated at the end of the frame
	always_comb begin
		if (!crc_en && edge_cnt == `CHSP_SHORT_BITS) begin
			frame24 = rx_sh[23:0];
		end else begin
			frame24 = rx_sh[31:8];
		end
		if (crc_en) begin
			len_ok = (edge_cnt == `CHSP_FULL_BITS);
		end else begin
			len_ok = (edge_cnt == `CHSP_SHORT_BITS) || (edge_cnt == `CHSP_FULL_BITS);
		end
	end
	chsp_crc8 #(.W(24)) u_rx_crc (
		.data (frame24),
		.crc  (rx_crc)
	);
	assign crc_ok   = !crc_en || (rx_crc == rx_sh[7:0]);
	assign guard_ok = frame24[23] == ~frame24[22];
	assign addr_ok  = frame24[22:21] == {lvl[4], lvl[3]};
	assign accept   = sync_rise & len_ok & crc_ok & guard_ok & addr_ok;
	assign cmd_reg  = frame24[20:16];
	assign cmd_data = frame24[15:0];

	// sticky error sources and write-one clears; a new error beats a clear
	always_comb begin
		diag_set = 3'b000;
		diag_set[`CHSP_DIAG_COUNT] = sync_rise & ~len_ok;
		diag_set[`CHSP_DIAG_CRC]   = sync_rise & len_ok & ~crc_ok;
		diag_set[`CHSP_DIAG_GUARD] = sync_rise & len_ok & crc_ok & ~guard_ok;
		diag_clr = 3'b000;
		if (accept && cmd_reg == `CHSP_REG_DIAG) begin
			diag_clr = cmd_data[2:0];
		end
	end

	// diagnostic results register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			diag <= 3'b000;
		end else begin
			diag <= (diag & ~diag_clr) | diag_set;
		end
	end

	// fault output; the check error is gated by the fault configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_n <= 1'b1;
		end else begin
			fault_n <= ~((diag[`CHSP_DIAG_CRC] & flt_cfg) | diag[`CHSP_DIAG_GUARD]
				| diag[`CHSP_DIAG_COUNT]);
		end
	end

	// control registers written by accepted frames
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_en <= `CHSP_CRC_EN_RST;
			rb_mode <= CHSP_RB_TWO_STAGE;
			rb_sel <= `CHSP_REG_NOP;
			flt_cfg <= `CHSP_FLT_CFG_RST;
		end else if (accept) begin
			if (cmd_reg == `CHSP_REG_CTRL) begin
				crc_en <= cmd_data[`CHSP_CTRL_CRC_EN];
				rb_mode <= chsp_rb_mode_e'(cmd_data[`CHSP_CTRL_MODE_LO +: 2]);
			end else if (cmd_reg == `CHSP_REG_RB_SEL) begin
				rb_sel <= cmd_data[4:0];
			end else if (cmd_reg == `CHSP_REG_FLT_CFG) begin
				flt_cfg <= cmd_data[0];
			end
		end
	end

	// write port for every other register address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_valid <= 1'b0;
			wr_addr <= 5'h00;
			wr_data <= 16'h0000;
		end else begin
			wr_valid <= accept && cmd_reg > `CHSP_REG_STATUS;
			if (accept) begin
				wr_addr <= cmd_reg;
				wr_data <= cmd_data;
			end
		end
	end

	// register read mux for readback
	assign status_word = {14'h0000, |diag, ~fault_n};
	always_comb begin
		if (rb_sel == `CHSP_REG_CTRL) begin
			sel_data = {13'h0000, rb_mode, crc_en};
		end else if (rb_sel == `CHSP_REG_RB_SEL) begin
			sel_data = {11'h000, rb_sel};
		end else if (rb_sel == `CHSP_REG_FLT_CFG) begin
			sel_data = {15'h0000, flt_cfg};
		end else if (rb_sel == `CHSP_REG_DIAG) begin
			sel_data = {13'h0000, diag};
		end else if (rb_sel == `CHSP_REG_STATUS) begin
			sel_data = status_word;
		end else begin
			sel_data = 16'h0000;
		end
	end

	// outgoing frame content by readback mode
	always_comb begin
		case (rb_mode)
			CHSP_RB_TWO_STAGE: begin
				tx_word = {`CHSP_SYNC_PAT, ~fault_n, rb_sel, sel_data};
			end
			CHSP_RB_ECHO: begin
				if (echo_phase) begin
					tx_word = {`CHSP_SYNC_PAT, ~fault_n, echo_word[20:0]};
				end else begin
					tx_word = {`CHSP_SYNC_PAT, ~fault_n, `CHSP_REG_STATUS, status_word};
				end
			end
			default: begin
				tx_word = {`CHSP_SYNC_PAT, ~fault_n, `CHSP_REG_STATUS, status_word};
			end
		endcase
	end
	chsp_crc8 #(.W(24)) u_tx_crc (
		.data (tx_word),
		.crc  (tx_crc)
	);

	// echo bookkeeping and shared-strobe ownership
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			echo_word <= 24'h00_0000;
			echo_phase <= 1'b0;
			addr_hit <= 1'b0;
		end else begin
			if (accept) begin
				echo_word <= frame24;
			end
			if (sync_rise) begin
				addr_hit <= len_ok & addr_ok;
			end
			if (sync_fall && rb_mode == CHSP_RB_ECHO) begin
				echo_phase <= ~echo_phase;
			end
		end
	end

	// output shift register: loaded at frame start, advanced on rising clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_sh <= 32'h0000_0000;
			sdo_oe_q <= 1'b0;
		end else if (sync_fall) begin
			tx_sh <= {tx_word, tx_crc};
			sdo_oe_q <= (rb_mode != CHSP_RB_SHARED) || addr_hit;
		end else if (sync_rise) begin
			sdo_oe_q <= 1'b0;
		end else if (clk_rise) begin
			tx_sh <= {tx_sh[30:0], 1'b0};
		end
	end
	assign link.sdo_o  = tx_sh[31];
	assign link.sdo_oe = sdo_oe_q;
endmodule
`default_nettype wire

/* File: test/chsp_link_monitor.sv */
// wire-level checks on the serial link between controller and device ends
`timescale 1ns/10ps
`default_nettype none
`include "chsp_consts.svh"
module chsp_link_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic sdo
);
	logic       sclk_q;
	logic [5:0] falls;
	logic       guard;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// previous clock level, for finding falling edges
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sclk_q <= 1'h1;
		else
			sclk_q <= sclk;
	end

	// falling edges counted within the current frame
	always_ff @(posedge aclk) begin
		if (!aresetn || sync_n)
			falls <= 6'h00;
		else if (sclk_q && !sclk)
			falls <= falls + 6'h01;
	end

	// first bit of a frame is the guard bit
	always_ff @(posedge aclk) begin
		if (sclk_q && !sclk && falls == 6'h00)
			guard <= sdi;
	end

	a_sclk_idle: assert property (sync_n |-> sclk)
		else $error("serial clock not high outside a frame");
	a_sdi_steady: assert property ($fell(sclk) |-> $stable(sdi))
		else $error("data changed at the sampling edge");
	a_frame_edges: assert property ($rose(sync_n) |->
		falls == `CHSP_FULL_BITS || falls == `CHSP_SHORT_BITS)
		else $error("frame closed with a wrong edge count");
	a_ret_sync: assert property ($fell(sclk) && falls == 6'h00 && sdo_oe |->
		sdo_o && sdo)
		else $error("returned frame does not open with a one");
	a_sclk_low: assert property ($fell(sclk) |-> !sclk[*8] ##1 sclk)
		else $error("serial clock low phase has wrong length");
	a_sync_lead: assert property ($fell(sync_n) |-> sclk[*8] ##1 !sclk)
		else $error("first clock fall not one half period after strobe");
	a_sync_gap: assert property ($rose(sync_n) |-> sync_n[*8])
		else $error("strobe gap between frames too short");
	a_guard_inv: assert property ($fell(sclk) && falls == 6'h01 |-> sdi != guard)
		else $error("guard bit equals the next bit");
	a_oe_start: assert property ($rose(sdo_oe) |-> !sync_n)
		else $error("device drove output outside a frame");
endmodule
`default_nettype wire

/* File: test/test_checked_serial_host_port.sv */
// self-checking bench: controller and device ends joined over the serial link
`timescale 1ns/10ps
`default_nettype none
`include "chsp_consts.svh"
module test_checked_serial_host_port;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [3:0]  awaddr = 4'h0;
	logic        awvalid = 1'h0;
	logic        awready;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hf;
	logic        wvalid = 1'h0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'h0;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'h0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'h0;
	logic        fault_n;
	logic        fault2_n;
	logic        wv1;
	logic        wv2;
	logic [4:0]  wa1;
	logic [15:0] wd1;
	logic [31:0] r;
	logic [31:0] q;
	logic [1:0]  resp;
	int          n_errors = 0;
	int          check_count = 0;
	int          n_wr1 = 0;
	int          n_wr2 = 0;

	chsp_link_if link ();
	chsp_link_if link2 ();

	chsp_ctl_end i_chsp_ctl_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link));
	chsp_dev_end i_chsp_dev_end (.aclk(aclk), .aresetn(aresetn), .link(link),
		.board_addr_strap0(1'h1), .board_addr_strap1(1'h1), .fault_n(fault_n),
		.wr_valid(wv1), .wr_addr(wa1), .wr_data(wd1));
	// second device on a link driven by the bench, for faulty frames
	chsp_dev_end i_chsp_dev_end2 (.aclk(aclk), .aresetn(aresetn), .link(link2),
		.board_addr_strap0(1'h0), .board_addr_strap1(1'h0), .fault_n(fault2_n),
		.wr_valid(wv2), .wr_addr(), .wr_data());
	chsp_link_monitor i_chsp_link_monitor (.aclk(aclk), .aresetn(aresetn),
		.sclk(link.sclk), .sync_n(link.sync_n), .sdi(link.sdi), .sdo_o(link.sdo_o),
		.sdo_oe(link.sdo_oe), .sdo(link.sdo));

	// 20 MHz clock
	always #(`CHSP_CLK_NS / 2) aclk = ~aclk;

	// count accepted writes on both devices
	always @(posedge aclk) begin
		if (wv1 === 1'h1) n_wr1++;
		if (wv2 === 1'h1) n_wr2++;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// frame sealed with its check byte, msb first from a zero remainder
	function automatic logic [31:0] seal(input logic [23:0] t);
		logic [7:0] c;
		c = `CHSP_CRC_INIT;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'h0} ^ ((c[7] ^ t[i]) ? `CHSP_CRC_POLY : 8'h00);
		return {t, c};
	endfunction

	function automatic logic [31:0] fr(input logic [1:0] b, input logic [4:0] a,
		input logic [15:0] d);
		return seal({~b[1], b, a, d});
	endfunction

	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			resp = bresp;
		end while (!bvalid);
		bready <= 1'h0;
		@(posedge aclk);
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			d = rdata;
			resp = rresp;
		end while (!rvalid);
		rready <= 1'h0;
		@(posedge aclk);
	endtask

	// one frame through the controller, returning what came back
	task automatic tx(input logic [1:0] b, input logic [4:0] a, input logic [15:0] d,
		output logic [31:0] rx);
		logic [31:0] s;
		axw(`CHSP_OFS_TX, {9'h000, b, a, d});
		@(posedge link.sync_n);
		do axr(`CHSP_OFS_STAT, s); while (s[0]);
		axr(`CHSP_OFS_RX, rx);
	endtask

	// bench-made frame of n edges on the second link, msb first
	task automatic bb(input logic [31:0] f, input int n, output logic [31:0] rx);
		rx = 32'h0000_0000;
		link2.sync_n <= 1'h0;
		link2.sdi <= f[31];
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge aclk);
			link2.sclk <= 1'h0;
			repeat (8) @(posedge aclk);
			rx = {rx[30:0], link2.sdo};
			link2.sclk <= 1'h1;
			link2.sdi <= (i < 31) ? f[30 - i] : 1'h0;
		end
		repeat (8) @(posedge aclk);
		link2.sync_n <= 1'h1;
		repeat (24) @(posedge aclk);
	endtask

	task automatic t_write();
		axr(`CHSP_OFS_CTRL, r);
		chk("checking at reset", r[0], 1'h1);
		chk("read response", resp, 2'h0);
		tx(2'h3, 5'h10, 16'ha5c3, r);
		chk("write count", n_wr1, 32'h0000_0001);
		chk("write addr", wa1, 5'h10);
		chk("write data", wd1, 16'ha5c3);
		tx(2'h1, 5'h11, 16'h1234, r);
		chk("foreign board", n_wr1, 32'h0000_0001);
		tx(2'h3, `CHSP_REG_RB_SEL, {11'h000, `CHSP_REG_FLT_CFG}, r);
		tx(2'h3, `CHSP_REG_NOP, 16'h0000, r);
		chk("readback", r, seal({2'h2, 1'h0, `CHSP_REG_FLT_CFG, 16'h0001}));
		axr(`CHSP_OFS_STAT, q);
		chk("returned frame ok", q[2:0], 3'h6);
	endtask

	task automatic t_count();
		axw(`CHSP_OFS_CTRL, 32'h0000_0000);
		chk("write response", resp, 2'h0);
		tx(2'h3, 5'h12, 16'h0bad, r);
		chk("short frame fault", fault_n, 1'h0);
		chk("short frame dropped", n_wr1, 32'h0000_0001);
		axw(`CHSP_OFS_CTRL, 32'h0000_0001);
		tx(2'h3, `CHSP_REG_RB_SEL, {11'h000, `CHSP_REG_DIAG}, r);
		tx(2'h3, `CHSP_REG_NOP, 16'h0000, r);
		chk("count flag", r[23:8], 16'h0004);
		chk("fault bit", r[29], 1'h1);
		tx(2'h3, `CHSP_REG_DIAG, 16'h0004, r);
		chk("fault released", fault_n, 1'h1);
		tx(2'h3, `CHSP_REG_CTRL, 16'h0000, r);
		axw(`CHSP_OFS_CTRL, 32'h0000_0000);
		tx(2'h3, 5'h13, 16'hbeef, r);
		chk("short write", wd1, 16'hbeef);
		tx(2'h3, `CHSP_REG_CTRL, 16'h0001, r);
		axw(`CHSP_OFS_CTRL, 32'h0000_0001);
	endtask

	task automatic t_modes();
		for (logic [2:0] m = 3'h1; m < 3'h4; m++) begin
			tx(2'h3, `CHSP_REG_CTRL, {13'h0000, m[1:0], 1'h1}, r);
			tx(2'h3, `CHSP_REG_NOP, 16'h0000, r);
			tx(2'h3, `CHSP_REG_NOP, 16'h0000, q);
			if (m == 3'h3)
				chk("echo alternates", (r[28:24] == 5'h05) ^ (q[28:24] == 5'h05), 1'h1);
			else
				chk("status each frame", q[28:24], `CHSP_REG_STATUS);
		end
		tx(2'h3, `CHSP_REG_CTRL, 16'h0001, r);
	endtask

	task automatic t_faults();
		bb(fr(2'h0, 5'h10, 16'h1111) ^ 32'h0000_0001, 32, r);
		chk("check fault", fault2_n, 1'h0);
		chk("check dropped", n_wr2, 32'h0000_0000);
		bb(fr(2'h0, `CHSP_REG_RB_SEL, {11'h000, `CHSP_REG_DIAG}), 32, r);
		bb(fr(2'h0, `CHSP_REG_NOP, 16'h0000), 32, r);
		chk("check flag", r[23:8], 16'h0001);
		bb(fr(2'h0, `CHSP_REG_DIAG, 16'h0001), 32, r);
		chk("flag cleared", fault2_n, 1'h1);
		bb(fr(2'h0, `CHSP_REG_FLT_CFG, 16'h0000), 32, r);
		bb(fr(2'h0, 5'h10, 16'h1111) ^ 32'h0000_0001, 32, r);
		chk("fault masked", fault2_n, 1'h1);
		bb(seal({1'h0, 2'h0, 5'h10, 16'h2222}), 32, r);
		chk("guard fault", fault2_n, 1'h0);
		chk("guard dropped", n_wr2, 32'h0000_0000);
		bb(fr(2'h0, `CHSP_REG_CTRL, 16'h0000), 32, r);
		bb(fr(2'h0, 5'h14, 16'h5a5a) ^ 32'h0000_00ff, 32, r);
		chk("tail ignored", n_wr2, 32'h0000_0001);
		bb(fr(2'h0, 5'h15, 16'h3c3c), 24, r);
		chk("short accepted", n_wr2, 32'h0000_0002);
	endtask

	// main sequence
	initial begin
		link2.sclk <= 1'h1;
		link2.sync_n <= 1'h1;
		link2.sdi <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (4) @(posedge aclk);
		chk("fault idle", fault_n, 1'h1);
		t_write();
		t_count();
		t_modes();
		t_faults();
		complete_run();
	end

	// watchdog
	initial begin
		repeat (60000) @(posedge aclk);
		n_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
